// file: include/sta_pkg.sv
`default_nettype none
// ****************************************************************
// Segmented acquisition constants
// ****************************************************************
package sta_pkg;
    // Register indices; byte address is four times the index
    localparam logic [13:0] IDX_MODE     = 14'h251C; // Operating mode select
    localparam logic [13:0] IDX_MEM_LO   = 14'h2710; // Total sample count, low word
    localparam logic [13:0] IDX_MEM_HI   = 14'h2711; // Total sample count, high word
    localparam logic [13:0] IDX_SEG_LO   = 14'h271A; // Segment length, low word
    localparam logic [13:0] IDX_SEG_HI   = 14'h271B; // Segment length, high word
    localparam logic [13:0] IDX_LOOPS    = 14'h2724; // Segment count limit
    localparam logic [13:0] IDX_POST_LO  = 14'h2774; // After trigger samples, low word
    localparam logic [13:0] IDX_POST_HI  = 14'h2775; // After trigger samples, high word
    localparam logic [13:0] IDX_CTRL     = 14'h2800; // Start and stop commands
    localparam logic [13:0] IDX_STATUS   = 14'h2801; // Live state
    localparam logic [13:0] IDX_IRQ_STAT = 14'h2802; // Sticky events, cleared by read
    localparam logic [13:0] IDX_IRQ_MASK = 14'h2803; // Event enables
    localparam logic [13:0] IDX_SEG_DONE = 14'h2804; // Segments finished so far
    // Mode codes
    localparam logic [31:0] MODE_STD_SEG  = 32'h0000_0002; // Standard segmented mode
    localparam logic [31:0] MODE_FIFO_SEG = 32'h0000_0020; // Streaming segmented mode
    // Control bits
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP  = 1;
    // Status bits
    localparam int ST_ARMED    = 0;
    localparam int ST_CAPTURE  = 1;
    localparam int ST_DONE     = 2;
    localparam int ST_MODE_ERR = 3;
    // Event bits
    localparam int EV_SEG_DONE = 0;
    localparam int EV_ACQ_DONE = 1;
    localparam int EV_W        = 2;
    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [63:0] RST_DWRD = 64'h0000_0000_0000_0000;
    // Timing
    localparam int CLK_NS     = 100; // Clock period
    localparam int REARM_NS   = 400; // Re-arm interval, least time
    localparam int REARM_CYC  = (REARM_NS + CLK_NS - 1) / CLK_NS;
    // States, one-hot
    typedef enum logic [3:0] {
        S_IDLE  = 4'b0001,
        S_ARM   = 4'b0010,
        S_CAPT  = 4'b0100,
        S_REARM = 4'b1000
    } sta_state_type;
endpackage
`default_nettype wire

// file: design/sta_count.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Clearable event counter
// ****************************************************************
module sta_count #(
    parameter int W = 32
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_clr,   // Clear, wins over increment
    input  wire logic         i_inc,   // Count one
    output logic [W-1:0]      o_cnt    // Current count
);
    // Count register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cnt <= '0;
        end else if (i_clr) begin
            o_cnt <= '0;
        end else if (i_inc) begin
            o_cnt <= o_cnt + W'(1);
        end
    end
endmodule // sta_count
`default_nettype wire

// file: design/sta_delay.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Programmable sample delay, circular pre-trigger store
// ****************************************************************
module sta_delay #(
    parameter int DW = 8,  // Sample width
    parameter int AW = 13  // Depth is two to this power
) (
    input  wire logic          i_clk,
    input  wire logic          i_rst_n,
    input  wire logic          i_valid,  // Input sample present
    input  wire logic [DW-1:0] i_data,   // Input sample
    input  wire logic [AW-1:0] i_delay,  // Delay in samples, zero means full depth
    output logic               o_valid,  // Delayed sample present
    output logic [DW-1:0]      o_data    // Sample written i_delay samples ago
);
    logic [DW-1:0] mem [0:(1<<AW)-1]; // Circular store
    logic [AW-1:0] wp_r;              // Write pointer

    // Pointer and valid; data holds no reset
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wp_r    <= '0;
            o_valid <= 1'b0;
        end else begin
            o_valid <= i_valid;
            if (i_valid) begin
                wp_r <= wp_r + AW'(1);
            end
        end
    end

    // Read the old sample before it is overwritten
    always_ff @(posedge i_clk) begin
        if (i_valid) begin
            o_data  <= mem[wp_r - i_delay];
            mem[wp_r] <= i_data;
        end
    end
endmodule // sta_delay
`default_nettype wire

// file: design/sta_core.sv
// Operation
// - Memory split into equal length segments
// - One segment filled per trigger, no restart
// - Trigger re-armed by hardware after short gap
// - After-trigger samples recorded per trigger
// - Segment length counts pre plus post samples
// - Pre count is length minus post count
// - Standard mode stops at total sample count
// - Mode code 2 selects standard segmented
// - Mode code 32 selects streaming segmented
// - Streaming runs until stop or limit
// - Streaming delivers segment samples only
// - Streaming segment limit zero means endless
`timescale 1ns/1ps
`default_nettype none
module sta_core #(
    parameter int DW    = 8,   // Sample width
    parameter int CNT_W = 34,  // Internal sample count width
    parameter int PRE_W = 13,  // Pre-trigger store depth, two to this power
    parameter int ADDR_W = 16  // Register byte address width
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    // Register port
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [31:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic [31:0]            o_rdata,
    // Sample stream and trigger
    input  wire logic              i_smp_valid,
    input  wire logic [DW-1:0]     i_smp_data,
    input  wire logic              i_trig,
    // On-board memory write port, standard mode
    output logic                   o_mem_we,
    output logic [CNT_W-1:0]       o_mem_addr,
    output logic [DW-1:0]          o_mem_data,
    // Segment stream, streaming mode
    output logic                   o_fifo_valid,
    output logic [DW-1:0]          o_fifo_data,
    // Status
    output logic                   o_armed,
    output logic                   o_irq
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    sta_pkg::sta_state_type st_r, st_nxt;  // Acquisition state
    logic [31:0]        mode_r;            // Operating mode select
    logic [63:0]        mem_r;             // Total sample count
    logic [63:0]        seg_r;             // Segment length
    logic [31:0]        loops_r;           // Segment count limit
    logic [63:0]        post_r;            // After trigger samples
    logic [sta_pkg::EV_W-1:0] mask_r;      // Event enables
    logic [sta_pkg::EV_W-1:0] ev_r;        // Sticky events
    logic               done_r;            // Acquisition finished
    logic               mode_err_r;        // Start refused for bad mode
    logic [31:0]        rd_nxt;            // Read mux
    logic [13:0]        idx;               // Word index of access
    logic               is_std, is_fifo;   // Decoded mode
    logic [CNT_W-1:0]   seg_len, post_len, pre_len, mem_len;
    logic [CNT_W-1:0]   fill_cnt, in_seg, total;
    logic [31:0]        segs;
    logic [2:0]         rearm_cnt_r;       // Re-arm timer
    logic               start, stop, trig_ok, seg_end, lim_hit;
    logic               dly_v;
    logic [DW-1:0]      dly_d;

    localparam logic [2:0] REARM_LAST = 3'(sta_pkg::REARM_CYC - 1);

    assign idx      = i_addr[ADDR_W-1:2];
    assign start    = i_wr && idx == sta_pkg::IDX_CTRL && i_wdata[sta_pkg::CTRL_START];
    assign stop     = i_wr && idx == sta_pkg::IDX_CTRL && i_wdata[sta_pkg::CTRL_STOP];
    assign is_std   = mode_r == sta_pkg::MODE_STD_SEG;
    assign is_fifo  = mode_r == sta_pkg::MODE_FIFO_SEG;
    assign seg_len  = seg_r[CNT_W-1:0];
    assign post_len = post_r[CNT_W-1:0];
    assign mem_len  = mem_r[CNT_W-1:0];
    // Pre part derived from length and post
    assign pre_len  = seg_len - post_len;

    // ****************************************************************
    // Register writes
    // ****************************************************************
    // Parameter registers; limits are trusted, software checks them
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_r  <= sta_pkg::RST_WORD;
            mem_r   <= sta_pkg::RST_DWRD;
            seg_r   <= sta_pkg::RST_DWRD;
            loops_r <= sta_pkg::RST_WORD;
            post_r  <= sta_pkg::RST_DWRD;
            mask_r  <= '0;
        end else if (i_wr) begin
            unique case (idx)
                sta_pkg::IDX_MODE:     mode_r        <= i_wdata;
                sta_pkg::IDX_MEM_LO:   mem_r[31:0]   <= i_wdata;
                sta_pkg::IDX_MEM_HI:   mem_r[63:32]  <= i_wdata;
                sta_pkg::IDX_SEG_LO:   seg_r[31:0]   <= i_wdata;
                sta_pkg::IDX_SEG_HI:   seg_r[63:32]  <= i_wdata;
                sta_pkg::IDX_LOOPS:    loops_r       <= i_wdata;
                sta_pkg::IDX_POST_LO:  post_r[31:0]  <= i_wdata;
                sta_pkg::IDX_POST_HI:  post_r[63:32] <= i_wdata;
                sta_pkg::IDX_IRQ_MASK: mask_r        <= i_wdata[sta_pkg::EV_W-1:0];
                default: begin
                    // Unmapped, read-only or command word, nothing stored
                end
            endcase
        end
    end

    // ****************************************************************
    // Register reads
    // ****************************************************************
    // Read mux; unmapped words read zero
    always_comb begin
        rd_nxt = sta_pkg::RST_WORD;
        unique case (idx)
            sta_pkg::IDX_MODE:     rd_nxt = mode_r;
            sta_pkg::IDX_MEM_LO:   rd_nxt = mem_r[31:0];
            sta_pkg::IDX_MEM_HI:   rd_nxt = mem_r[63:32];
            sta_pkg::IDX_SEG_LO:   rd_nxt = seg_r[31:0];
            sta_pkg::IDX_SEG_HI:   rd_nxt = seg_r[63:32];
            sta_pkg::IDX_LOOPS:    rd_nxt = loops_r;
            sta_pkg::IDX_POST_LO:  rd_nxt = post_r[31:0];
            sta_pkg::IDX_POST_HI:  rd_nxt = post_r[63:32];
            sta_pkg::IDX_IRQ_MASK: rd_nxt = 32'(mask_r);
            sta_pkg::IDX_IRQ_STAT: rd_nxt = 32'(ev_r);
            sta_pkg::IDX_SEG_DONE: rd_nxt = segs;
            sta_pkg::IDX_STATUS: begin
                rd_nxt[sta_pkg::ST_ARMED]    = st_r == sta_pkg::S_ARM;
                rd_nxt[sta_pkg::ST_CAPTURE]  = st_r == sta_pkg::S_CAPT;
                rd_nxt[sta_pkg::ST_DONE]     = done_r;
                rd_nxt[sta_pkg::ST_MODE_ERR] = mode_err_r;
            end
            default: rd_nxt = sta_pkg::RST_WORD;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= sta_pkg::RST_WORD;
        end else if (i_rd) begin
            o_rdata <= rd_nxt;
        end else begin
            o_rdata <= sta_pkg::RST_WORD;
        end
    end

    // ****************************************************************
    // Pre-trigger store and counters
    // ****************************************************************
    // Circular store delays input by the pre part
    sta_delay #(.DW(DW), .AW(PRE_W)) u_delay (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_valid (i_smp_valid),
        .i_data  (i_smp_data),
        .i_delay (pre_len[PRE_W-1:0]),
        .o_valid (dly_v),
        .o_data  (dly_d)
    );

    // Samples seen since arming; trigger waits for a full pre part
    sta_count #(.W(CNT_W)) u_fill (
        .i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_clr(st_r != sta_pkg::S_ARM), .i_inc(i_smp_valid), .o_cnt(fill_cnt)
    );
    // Samples stored in the current segment
    // Post part follows trigger in segment
    sta_count #(.W(CNT_W)) u_inseg (
        .i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_clr(st_r != sta_pkg::S_CAPT), .i_inc(dly_v), .o_cnt(in_seg)
    );
    // Samples stored since start, also the memory address
    sta_count #(.W(CNT_W)) u_total (
        .i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_clr(start), .i_inc(st_r == sta_pkg::S_CAPT && dly_v), .o_cnt(total)
    );
    // Segments finished since start
    sta_count #(.W(32)) u_segs (
        .i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_clr(start), .i_inc(seg_end), .o_cnt(segs)
    );

    assign trig_ok = st_r == sta_pkg::S_ARM && i_trig && fill_cnt >= pre_len;
    // Segment ends when pre plus post are stored
    assign seg_end = st_r == sta_pkg::S_CAPT && dly_v && in_seg == seg_len - CNT_W'(1);
    // Standard mode limit; streaming limit, zero is endless
    assign lim_hit = (is_std && total + CNT_W'(1) == mem_len)
                  || (is_fifo && loops_r != sta_pkg::RST_WORD && segs + 32'(1) == loops_r);

    // ****************************************************************
    // Acquisition sequence
    // ****************************************************************
    // Next state; stop wins over every other cause
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            sta_pkg::S_IDLE: begin
                if (start && (is_std || is_fifo)) begin
                    st_nxt = sta_pkg::S_ARM;
                end
            end
            sta_pkg::S_ARM: begin
                if (trig_ok) begin
                    st_nxt = sta_pkg::S_CAPT;
                end
            end
            sta_pkg::S_CAPT: begin
                if (seg_end && lim_hit) begin
                    st_nxt = sta_pkg::S_IDLE;
                end else if (seg_end) begin
                    st_nxt = sta_pkg::S_REARM;
                end
            end
            sta_pkg::S_REARM: begin
                if (rearm_cnt_r == REARM_LAST) begin
                    st_nxt = sta_pkg::S_ARM;
                end
            end
            default: st_nxt = sta_pkg::S_IDLE;
        endcase
        if (stop) begin
            st_nxt = sta_pkg::S_IDLE;
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= sta_pkg::S_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Re-arm timer runs only in the gap
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rearm_cnt_r <= '0;
        end else if (st_r == sta_pkg::S_REARM) begin
            rearm_cnt_r <= rearm_cnt_r + 3'(1);
        end else begin
            rearm_cnt_r <= '0;
        end
    end

    // Done and mode error flags, renewed on each start written while idle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            done_r     <= 1'b0;
            mode_err_r <= 1'b0;
        end else if (start && st_r == sta_pkg::S_IDLE) begin
            done_r     <= 1'b0;
            mode_err_r <= !(is_std || is_fifo);
        end else if (seg_end && lim_hit) begin
            done_r     <= 1'b1;
        end
    end

    // ****************************************************************
    // Sample output
    // ****************************************************************
    // Segments laid end to end at equal length; stream only segment data
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mem_we     <= 1'b0;
            o_mem_addr   <= '0;
            o_mem_data   <= '0;
            o_fifo_valid <= 1'b0;
            o_fifo_data  <= '0;
        end else begin
            o_mem_we     <= st_r == sta_pkg::S_CAPT && dly_v && is_std;
            o_fifo_valid <= st_r == sta_pkg::S_CAPT && dly_v && is_fifo;
            if (st_r == sta_pkg::S_CAPT && dly_v) begin
                o_mem_addr  <= total;
                o_mem_data  <= dly_d;
                o_fifo_data <= dly_d;
            end
        end
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    // Sticky events; a new event beats the read that clears
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ev_r <= '0;
        end else begin
            if (i_rd && idx == sta_pkg::IDX_IRQ_STAT) begin
                ev_r <= '0;
            end
            if (seg_end) begin
                ev_r[sta_pkg::EV_SEG_DONE] <= 1'b1;
            end
            if (seg_end && lim_hit) begin
                ev_r[sta_pkg::EV_ACQ_DONE] <= 1'b1;
            end
        end
    end

    assign o_irq   = |(ev_r & mask_r);
    assign o_armed = st_r == sta_pkg::S_ARM;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_trig_opens: assert property (trig_ok && !stop |=> st_r == sta_pkg::S_CAPT)
        else $error("trigger did not open a segment");
    a_rearm_gap: assert property ($rose(st_r == sta_pkg::S_REARM) && !stop
        |-> (st_r == sta_pkg::S_REARM) [*4] ##1 st_r == sta_pkg::S_ARM)
        else $error("re-arm gap wrong length");
    a_seg_length: assert property (seg_end |-> in_seg + CNT_W'(1) == seg_len)
        else $error("segment ended at wrong count");
    a_pre_derive: assert property (st_r == sta_pkg::S_CAPT |-> pre_len + post_len == seg_len)
        else $error("pre part not length minus post");
    a_mem_stop: assert property (seg_end && is_std && total + CNT_W'(1) == mem_len && !stop
        |=> st_r == sta_pkg::S_IDLE ##1 !o_mem_we [*3])
        else $error("storing went on past total");
    a_std_no_stream: assert property (is_std && $stable(mode_r) |-> !o_fifo_valid)
        else $error("standard mode streamed data");
    a_fifo_no_mem: assert property (is_fifo && $stable(mode_r) |-> !o_mem_we)
        else $error("streaming mode wrote memory");
    a_stream_gaps: assert property (o_fifo_valid |-> $past(st_r) == sta_pkg::S_CAPT)
        else $error("gap sample streamed");
    a_loops_stop: assert property (seg_end && is_fifo && loops_r != sta_pkg::RST_WORD
        && segs + 32'(1) == loops_r && !stop |=> st_r == sta_pkg::S_IDLE && done_r)
        else $error("segment limit not honoured");
    a_endless: assert property (seg_end && is_fifo && loops_r == sta_pkg::RST_WORD && !stop
        |=> st_r == sta_pkg::S_REARM)
        else $error("endless streaming stopped");
    a_done_event: assert property (seg_end && lim_hit
        |=> ev_r[sta_pkg::EV_ACQ_DONE] && ev_r[sta_pkg::EV_SEG_DONE])
        else $error("completion not signalled");
    a_pre_filled: assert property ($rose(st_r == sta_pkg::S_CAPT) |-> $past(fill_cnt) >= $past(pre_len))
        else $error("segment opened before pre part held");
endmodule // sta_core
`default_nettype wire

// file: test/sta_host_sink.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Host side sink: takes delivered samples, checks their order
// ****************************************************************
module sta_host_sink #(
    parameter int SEG = 64  // Segment length in samples
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_mem_we,
    input  wire logic [33:0] i_mem_addr,
    input  wire logic [7:0]  i_mem_data,
    input  wire logic        i_fifo_valid,
    input  wire logic [7:0]  i_fifo_data,
    output logic [31:0]      o_mem_cnt,   // Samples stored so far
    output logic [31:0]      o_fifo_cnt,  // Samples streamed so far
    output logic [31:0]      o_bad        // Address slips or gaps inside a segment
);
    logic [7:0] last_mem_r;   // Previous stored sample
    logic [7:0] last_fifo_r;  // Previous streamed sample
    logic       mem_bad;      // Slip on this store
    logic       fifo_bad;     // Gap on this streamed sample
    // Samples within one segment are consecutive, address runs on
    assign mem_bad  = i_mem_we && ((i_mem_addr !== 34'(o_mem_cnt)) ||
                      ((o_mem_cnt % SEG) != 0 && i_mem_data !== last_mem_r + 8'h01));
    // Only segment samples reach the host, so no gap inside a block
    assign fifo_bad = i_fifo_valid && (o_fifo_cnt % SEG) != 0 &&
                      i_fifo_data !== last_fifo_r + 8'h01;
    // Counting; the host never stalls the stream
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mem_cnt   <= 32'h0000_0000;
            o_fifo_cnt  <= 32'h0000_0000;
            o_bad       <= 32'h0000_0000;
            last_mem_r  <= 8'h00;
            last_fifo_r <= 8'h00;
        end else begin
            o_bad <= o_bad + 32'(mem_bad) + 32'(fifo_bad);
            if (i_mem_we) begin
                o_mem_cnt  <= o_mem_cnt + 32'h0000_0001;
                last_mem_r <= i_mem_data;
            end
            if (i_fifo_valid) begin
                o_fifo_cnt  <= o_fifo_cnt + 32'h0000_0001;
                last_fifo_r <= i_fifo_data;
            end
        end
    end
endmodule // sta_host_sink
`default_nettype wire

// file: test/segmented_trigger_acquisition_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Bench: configure, trigger, count what reaches the host
// ****************************************************************
module segmented_trigger_acquisition_bench;
    logic i_clk, i_rst_n, i_wr, i_rd, i_smp_valid, i_trig, o_mem_we, o_fifo_valid, o_armed, o_irq;
    logic [15:0] i_addr;
    logic [31:0] i_wdata, o_rdata, mem_cnt, fifo_cnt, bad, rv;
    logic [7:0]  i_smp_data, o_mem_data, o_fifo_data;
    logic [33:0] o_mem_addr;
    int          error_cnt, checks_done;
    sta_core dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_smp_valid(i_smp_valid),
        .i_smp_data(i_smp_data), .i_trig(i_trig), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
        .o_mem_data(o_mem_data), .o_fifo_valid(o_fifo_valid), .o_fifo_data(o_fifo_data),
        .o_armed(o_armed), .o_irq(o_irq));
    sta_host_sink host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_mem_we(o_mem_we),
        .i_mem_addr(o_mem_addr), .i_mem_data(o_mem_data), .i_fifo_valid(o_fifo_valid),
        .i_fifo_data(o_fifo_data), .o_mem_cnt(mem_cnt), .o_fifo_cnt(fifo_cnt), .o_bad(bad));
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    // Free running ramp of samples, so order slips show up at the sink
    always @(posedge i_clk) i_smp_data <= i_rst_n ? i_smp_data + 8'h01 : 8'h00;
    task automatic chk(input bit ok, input string m);
        checks_done++;
        if (!ok) begin
            error_cnt++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic report_and_stop();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [13:0] idx, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= {idx, 2'b00};
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [13:0] idx, output logic [31:0] d);
        @(posedge i_clk);
        i_addr <= {idx, 2'b00};
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    // Bounded wait for the stored or streamed total to reach n
    task automatic wait_cnt(input bit fifo, input logic [31:0] n);
        for (int i = 0; i < 3000 && (fifo ? fifo_cnt : mem_cnt) !== n; i++) @(posedge i_clk);
        chk((fifo ? fifo_cnt : mem_cnt) === n, "sample total not reached");
        if ((fifo ? fifo_cnt : mem_cnt) !== n) report_and_stop();
    endtask
    // One segment: wait for arming, let the pre part fill, trigger once
    task automatic segment(input bit fifo, input logic [31:0] n);
        logic [7:0] tv;  // Ramp value just before the trigger is taken
        for (int i = 0; i < 8 && o_armed !== 1'b1; i++) @(posedge i_clk);
        chk(o_armed === 1'b1, "not re-armed in time");
        if (o_armed !== 1'b1) report_and_stop();
        repeat (40) @(posedge i_clk);
        tv = i_smp_data;
        i_trig <= 1'b1;
        @(posedge i_clk);
        i_trig <= 1'b0;
        wait_cnt(fifo, n);
        // Last stored sample is the 32nd one from the trigger on
        chk((fifo ? o_fifo_data : o_mem_data) === tv + 8'h20, "segment content");
    endtask
    // Segment 64 with post 32 keeps 32 step rule and pre 32 within limit
    task automatic setup(input logic [31:0] mode, input logic [31:0] loops);
        wr(sta_pkg::IDX_MODE, mode);
        wr(sta_pkg::IDX_SEG_LO, 32'h0000_0040);
        wr(sta_pkg::IDX_POST_LO, 32'h0000_0020);
        wr(sta_pkg::IDX_MEM_LO, 32'h0000_0080);
        wr(sta_pkg::IDX_LOOPS, loops);
        wr(sta_pkg::IDX_IRQ_MASK, 32'h0000_0003);
        wr(sta_pkg::IDX_CTRL, 32'h0000_0001);
    endtask
    task automatic t_regs();
        rd(sta_pkg::IDX_SEG_LO, rv);
        chk(rv === sta_pkg::RST_WORD, "reset value");
        wr(sta_pkg::IDX_SEG_LO, 32'h0000_0040);
        rd(sta_pkg::IDX_SEG_LO, rv);
        chk(rv === 32'h0000_0040, "readback");
        rd(14'h0100, rv);
        chk(rv === 32'h0000_0000, "unmapped read");
        setup(32'h0000_0005, 32'h0000_0000);
        rd(sta_pkg::IDX_STATUS, rv);
        chk(rv[sta_pkg::ST_MODE_ERR] === 1'b1 && o_armed === 1'b0, "bad mode armed");
    endtask
    task automatic t_std();
        setup(sta_pkg::MODE_STD_SEG, 32'h0000_0000);
        segment(1'b0, 32'h0000_0040);
        segment(1'b0, 32'h0000_0080);
        repeat (20) @(posedge i_clk);
        chk(mem_cnt === 32'h0000_0080 && o_armed === 1'b0, "std not stopped");
        chk(o_irq === 1'b1 && fifo_cnt === 32'h0000_0000, "std irq or stream");
        rd(sta_pkg::IDX_IRQ_STAT, rv);
        chk(rv === 32'h0000_0003 && o_irq === 1'b0, "irq status clear");
    endtask
    task automatic t_fifo();
        setup(sta_pkg::MODE_FIFO_SEG, 32'h0000_0002);
        repeat (2) @(posedge i_clk);
        i_trig <= 1'b1;
        @(posedge i_clk);
        i_trig <= 1'b0;
        repeat (100) @(posedge i_clk);
        chk(fifo_cnt === 32'h0000_0000, "early trigger taken");
        segment(1'b1, 32'h0000_0040);
        segment(1'b1, 32'h0000_0080);
        repeat (60) @(posedge i_clk);
        chk(fifo_cnt === 32'h0000_0080 && o_armed === 1'b0, "limit not kept");
        setup(sta_pkg::MODE_FIFO_SEG, 32'h0000_0000);
        segment(1'b1, 32'h0000_00C0);
        segment(1'b1, 32'h0000_0100);
        // Stop once re-armed, so the re-arm gap runs its full length
        for (int i = 0; i < 8 && o_armed !== 1'b1; i++) @(posedge i_clk);
        chk(o_armed === 1'b1, "endless run not re-armed");
        if (o_armed !== 1'b1) report_and_stop();
        wr(sta_pkg::IDX_CTRL, 32'h0000_0002);
        repeat (60) @(posedge i_clk);
        chk(o_armed === 1'b0 && fifo_cnt === 32'h0000_0100, "stop ignored");
        chk(bad === 32'h0000_0000 && mem_cnt === 32'h0000_0080, "sample order");
    endtask
    initial begin
        error_cnt = 0;
        checks_done = 0;
        {i_rst_n, i_wr, i_rd, i_trig} = 4'h0;
        i_smp_valid = 1'b1;
        i_addr = 16'h0000;
        i_wdata = 32'h0000_0000;
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_regs();
        t_std();
        t_fifo();
        report_and_stop();
    end
endmodule // segmented_trigger_acquisition_bench
`default_nettype wire
